// ### usbofe_params.svh
// Register map, field positions, reset values and timing constants of the OTG event-flag block
`ifndef USBOFE_PARAMS_SVH
`define USBOFE_PARAMS_SVH

`define USBOFE_ADDR_W 8
`define USBOFE_OFF_FLAGS 8'h00
`define USBOFE_OFF_ENABLE 8'h04
`define USBOFE_OFF_STATUS 8'h08
`define USBOFE_OFF_CTRL 8'h0C

`define USBOFE_BIT_ID 7
`define USBOFE_BIT_MS 6
`define USBOFE_BIT_LINE 5
`define USBOFE_BIT_ACT 4
`define USBOFE_BIT_SESVD 3
`define USBOFE_BIT_SESEND 2
`define USBOFE_BIT_VBUSVD 0
`define USBOFE_FLAG_MASK 8'hFD
`define USBOFE_STAT_MASK 8'hAD
`define USBOFE_FLAG_RESET 8'h00
`define USBOFE_ENABLE_RESET 8'h00

`define USBOFE_CTRL_MODE_LSB 0
`define USBOFE_CTRL_LOWSPD 3
`define USBOFE_CTRL_ENGINE 4
`define USBOFE_CTRL_DMA 5
`define USBOFE_CTRL_SUSP 6

`define USBOFE_RESP_OKAY 2'h0
`define USBOFE_RESP_SLVERR 2'h2

`define USBOFE_CORE_MHZ 125
`define USBOFE_USB_MHZ 48
`define USBOFE_MS_US 1000
`define USBOFE_USB_TICKS_PER_MS (`USBOFE_USB_MHZ * `USBOFE_MS_US)
`define USBOFE_SYNC_SETTLE 3'h4

`endif

// ### usbofe_pkg.sv
// Types shared by the OTG event-flag block
package usbofe_pkg;

	typedef enum logic [2:0] {
		USBOFE_MODE_HOST = 3'b001,
		USBOFE_MODE_DEVICE = 3'b010,
		USBOFE_MODE_OTG = 3'b100
	} usbofe_mode_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [15:0] ms_cnt;
		logic tick48;
		logic tick_ms;
	} usbofe_tb_st_t;

	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] flags;
		logic [7:0] ien;
		usbofe_mode_t mode;
		logic low_speed;
		logic serial_engine_en;
		logic dma_en;
		logic suspend;
		logic primed;
		logic [5:0] pins_prev;
		logic [1:0] line_prev;
		logic [15:0] line_cnt;
		logic line_stable;
		logic [1:0] line_rep;
	} usbofe_top_st_t;

endpackage

// ### usbofe_tick_if.sv
// Time-base strobes passed from the divider to the flag logic
`timescale 1ns/10ps
`default_nettype none
interface usbofe_tick_if;
	logic tick48;
	logic tick_ms;
	modport src (output tick48, output tick_ms);
	modport snk (input tick48, input tick_ms);
endinterface
`default_nettype wire

// ### usbofe_timebase.sv
// Fractional 48 MHz enable and one-millisecond tick from the core clock
`timescale 1ns/10ps
`default_nettype none
`include "usbofe_params.svh"
module usbofe_timebase #(
	parameter int MS_TICKS = `USBOFE_USB_TICKS_PER_MS
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	usbofe_tick_if.src tick
);
	generate
		if (MS_TICKS < 2 || MS_TICKS > 65535) begin : g_bad
			$error("MS_TICKS out of range");
		end
	endgenerate

	localparam logic [7:0] ACC_INC = 8'(`USBOFE_USB_MHZ);
	localparam logic [7:0] ACC_MOD = 8'(`USBOFE_CORE_MHZ);
	localparam logic [15:0] MS_LAST = 16'(MS_TICKS - 1);

	usbofe_pkg::usbofe_tb_st_t st_r;
	usbofe_pkg::usbofe_tb_st_t st_nxt;
	logic [7:0] sum;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick48 = 1'b0;
		st_nxt.tick_ms = 1'b0;
		// Phase accumulator gives an average 48 MHz rate; jitter is one core cycle
		sum = st_r.acc + ACC_INC;
		if (sum >= ACC_MOD) begin
			st_nxt.acc = sum - ACC_MOD;
			st_nxt.tick48 = 1'b1;
			if (st_r.ms_cnt == MS_LAST) begin
				st_nxt.ms_cnt = 16'h0000;
				st_nxt.tick_ms = 1'b1;
			end else begin
				st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
			end
		end else begin
			st_nxt.acc = sum;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick.tick48 = st_r.tick48;
	assign tick.tick_ms = st_r.tick_ms;
endmodule
`default_nettype wire

// ### usbofe_sync.sv
// Three-flop pin synchroniser; a new level counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
`include "usbofe_params.svh"
module usbofe_sync #(
	parameter int WIDTH = 6
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_level,
	output logic o_valid
);
	generate
		if (WIDTH < 1) begin : g_bad
			$error("WIDTH must be at least one");
		end
	endgenerate

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] lvl_r;
	logic [2:0] settle_r;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (!i_rst_b) begin
					s1_r[g] <= 1'b0;
					s2_r[g] <= 1'b0;
					s3_r[g] <= 1'b0;
					lvl_r[g] <= 1'b0;
				end else begin
					s1_r[g] <= i_pins[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g]) begin
						lvl_r[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

	// Levels after reset are not trusted until the chain has filled
	// Four cycles, so the level stage has caught up; three gave false edges
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			settle_r <= 3'h0;
		end else if (settle_r != `USBOFE_SYNC_SETTLE) begin
			settle_r <= settle_r + 3'h1;
		end
	end

	assign o_level = lvl_r;
	assign o_valid = (settle_r == `USBOFE_SYNC_SETTLE);
endmodule
`default_nettype wire

// ### usbofe_top.sv
// OTG event flags, enables, status and control behind an AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "usbofe_params.svh"
module usbofe_top #(
	parameter int MS_TICKS = `USBOFE_USB_TICKS_PER_MS
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [7:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire logic I_ID,
	input wire logic I_DP,
	input wire logic I_DM,
	input wire logic I_SESS_VALID,
	input wire logic I_SESS_END,
	input wire logic I_VBUS_VALID,
	output logic O_IRQ,
	output logic [2:0] O_MODE,
	output logic O_LOW_SPEED,
	output logic O_SERIAL_ENGINE_EN,
	output logic O_DMA_EN,
	output logic O_LINE_STABLE
);
	generate
		if (MS_TICKS < 2 || MS_TICKS > 65535) begin : g_bad
			$error("MS_TICKS out of range");
		end
	endgenerate

	localparam int P_ID = 0;
	localparam int P_DP = 1;
	localparam int P_DM = 2;
	localparam int P_SV = 3;
	localparam int P_SE = 4;
	localparam int P_VV = 5;
	localparam logic [15:0] LINE_MS = 16'(MS_TICKS);

	usbofe_tick_if tick_if ();

	usbofe_timebase #(
		.MS_TICKS(MS_TICKS)
	) u_timebase (
		.i_clk(I_CORE_CLK),
		.i_rst_b(I_RST_B),
		.tick(tick_if.src)
	);

	logic [5:0] pins;
	logic pins_valid;

	usbofe_sync #(
		.WIDTH(6)
	) u_sync (
		.i_clk(I_CORE_CLK),
		.i_rst_b(I_RST_B),
		.i_pins({I_VBUS_VALID, I_SESS_END, I_SESS_VALID, I_DM, I_DP, I_ID}),
		.o_level(pins),
		.o_valid(pins_valid)
	);

	usbofe_pkg::usbofe_top_st_t st_r;
	usbofe_pkg::usbofe_top_st_t st_nxt;

	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_wr;
	logic wr_lane0;
	logic [7:0] wr_byte;
	logic [7:0] set;
	logic [7:0] clr;
	logic [7:0] status;
	logic [5:0] pin_chg;
	logic [1:0] line_now;
	logic single_ended_zero_state;
	logic jst;
	logic [2:0] mode_req;

	// Handshake outputs are combinational from the holding flags
	assign O_AWREADY = !st_r.aw_full;
	assign O_WREADY = !st_r.w_full;
	assign O_ARREADY = !st_r.rvalid;
	assign aw_hs = I_AWVALID && O_AWREADY;
	assign w_hs = I_WVALID && O_WREADY;
	assign ar_hs = I_ARVALID && O_ARREADY;
	// Write happens once both halves are held and the previous answer is gone
	assign do_wr = st_r.aw_full && st_r.w_full && !st_r.bvalid;
	assign wr_lane0 = do_wr && st_r.w_strb0;
	assign wr_byte = st_r.w_data[7:0];
	assign mode_req = wr_byte[`USBOFE_CTRL_MODE_LSB +: 3];

	// Line state as the serial engine sees it; J polarity flips for a low-speed host
	assign single_ended_zero_state = !pins[P_DP] && !pins[P_DM];
	assign jst = st_r.low_speed ? (pins[P_DM] && !pins[P_DP]) : (pins[P_DP] && !pins[P_DM]);
	assign line_now = {single_ended_zero_state, jst};

	assign pin_chg = st_r.primed ? (pins ^ st_r.pins_prev) : 6'h00;

	always_comb begin
		status = 8'h00;
		status[`USBOFE_BIT_ID] = pins[P_ID];
		status[`USBOFE_BIT_LINE] = st_r.line_stable;
		status[`USBOFE_BIT_SESVD] = pins[P_SV];
		status[`USBOFE_BIT_SESEND] = pins[P_SE];
		status[`USBOFE_BIT_VBUSVD] = pins[P_VV];
	end

	always_comb begin
		set = 8'h00;
		set[`USBOFE_BIT_ID] = pin_chg[P_ID];
		set[`USBOFE_BIT_MS] = tick_if.tick_ms;
		set[`USBOFE_BIT_LINE] = 1'b0;
		if (st_r.primed && tick_if.tick48 && st_r.line_cnt == LINE_MS - 16'h0001 &&
				line_now == st_r.line_prev && line_now != st_r.line_rep) begin
			set[`USBOFE_BIT_LINE] = 1'b1;
		end
		// Wake-up only counts while software has parked the link
		set[`USBOFE_BIT_ACT] = st_r.suspend &&
			(pin_chg[P_DP] || pin_chg[P_DM] || pin_chg[P_ID] || pin_chg[P_VV]);
		set[`USBOFE_BIT_SESVD] = pin_chg[P_SE] && pins[P_SE];
		set[`USBOFE_BIT_SESEND] = pin_chg[P_SE];
		set[`USBOFE_BIT_VBUSVD] = pin_chg[P_VV];
		set = set & `USBOFE_FLAG_MASK;
	end

	always_comb begin
		clr = 8'h00;
		if (wr_lane0 && st_r.aw_addr == `USBOFE_OFF_FLAGS) begin
			clr = wr_byte & `USBOFE_FLAG_MASK;
		end
	end

	always_comb begin
		st_nxt = st_r;

		if (aw_hs) begin
			st_nxt.aw_full = 1'b1;
			st_nxt.aw_addr = I_AWADDR;
		end
		if (w_hs) begin
			st_nxt.w_full = 1'b1;
			st_nxt.w_data = I_WDATA;
			st_nxt.w_strb0 = I_WSTRB[0];
		end
		if (st_r.bvalid && I_BREADY) begin
			st_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = `USBOFE_RESP_OKAY;
			case (st_r.aw_addr)
				`USBOFE_OFF_FLAGS: begin
				end
				`USBOFE_OFF_ENABLE: begin
					if (st_r.w_strb0) begin
						st_nxt.ien = wr_byte & `USBOFE_FLAG_MASK;
					end
				end
				`USBOFE_OFF_STATUS: begin
				end
				`USBOFE_OFF_CTRL: begin
					if (st_r.w_strb0) begin
						// Mode codes that are not one-hot keep the old mode
						case (mode_req)
							usbofe_pkg::USBOFE_MODE_HOST: begin
								st_nxt.mode = usbofe_pkg::USBOFE_MODE_HOST;
							end
							usbofe_pkg::USBOFE_MODE_DEVICE: begin
								st_nxt.mode = usbofe_pkg::USBOFE_MODE_DEVICE;
							end
							usbofe_pkg::USBOFE_MODE_OTG: begin
								st_nxt.mode = usbofe_pkg::USBOFE_MODE_OTG;
							end
							default: begin
							end
						endcase
						st_nxt.low_speed = wr_byte[`USBOFE_CTRL_LOWSPD];
						st_nxt.serial_engine_en = wr_byte[`USBOFE_CTRL_ENGINE];
						st_nxt.dma_en = wr_byte[`USBOFE_CTRL_DMA];
						st_nxt.suspend = wr_byte[`USBOFE_CTRL_SUSP];
					end
				end
				default: begin
					st_nxt.bresp = `USBOFE_RESP_SLVERR;
				end
			endcase
		end
		// Low speed only exists as host, whatever was written
		if (st_nxt.mode != usbofe_pkg::USBOFE_MODE_HOST) begin
			st_nxt.low_speed = 1'b0;
		end

		if (st_r.rvalid && I_RREADY) begin
			st_nxt.rvalid = 1'b0;
		end
		if (ar_hs) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = `USBOFE_RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			case (I_ARADDR)
				`USBOFE_OFF_FLAGS: begin
					st_nxt.rdata[7:0] = st_r.flags;
				end
				`USBOFE_OFF_ENABLE: begin
					st_nxt.rdata[7:0] = st_r.ien;
				end
				`USBOFE_OFF_STATUS: begin
					st_nxt.rdata[7:0] = status;
				end
				`USBOFE_OFF_CTRL: begin
					st_nxt.rdata[`USBOFE_CTRL_MODE_LSB +: 3] = st_r.mode;
					st_nxt.rdata[`USBOFE_CTRL_LOWSPD] = st_r.low_speed;
					st_nxt.rdata[`USBOFE_CTRL_ENGINE] = st_r.serial_engine_en;
					st_nxt.rdata[`USBOFE_CTRL_DMA] = st_r.dma_en;
					st_nxt.rdata[`USBOFE_CTRL_SUSP] = st_r.suspend;
				end
				default: begin
					st_nxt.rresp = `USBOFE_RESP_SLVERR;
				end
			endcase
		end

		// Set is applied after clear so a coincident event survives
		st_nxt.flags = ((st_r.flags & ~clr) | set) & `USBOFE_FLAG_MASK;

		if (pins_valid) begin
			st_nxt.primed = 1'b1;
			st_nxt.pins_prev = pins;
		end

		// Stability timer runs on the 48 MHz enable; any line change restarts it
		st_nxt.line_prev = line_now;
		if (!st_r.primed || line_now != st_r.line_prev) begin
			st_nxt.line_cnt = 16'h0000;
			st_nxt.line_stable = 1'b0;
		end else if (tick_if.tick48 && st_r.line_cnt != LINE_MS) begin
			st_nxt.line_cnt = st_r.line_cnt + 16'h0001;
			if (st_r.line_cnt == LINE_MS - 16'h0001) begin
				st_nxt.line_stable = 1'b1;
				st_nxt.line_rep = line_now;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			st_r <= '0;
			st_r.flags <= `USBOFE_FLAG_RESET;
			st_r.ien <= `USBOFE_ENABLE_RESET;
			st_r.mode <= usbofe_pkg::USBOFE_MODE_DEVICE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign O_IRQ = |(st_r.flags & st_r.ien);
	assign O_BVALID = st_r.bvalid;
	assign O_BRESP = st_r.bresp;
	assign O_RVALID = st_r.rvalid;
	assign O_RDATA = st_r.rdata;
	assign O_RRESP = st_r.rresp;
	assign O_MODE = st_r.mode;
	assign O_LOW_SPEED = st_r.low_speed;
	assign O_SERIAL_ENGINE_EN = st_r.serial_engine_en;
	assign O_DMA_EN = st_r.dma_en;
	assign O_LINE_STABLE = st_r.line_stable;
endmodule
`default_nettype wire

// ### usbofe_top_chk.sv
// Port-level assertions for the OTG event-flag block
`timescale 1ns/10ps
`default_nettype none
module usbofe_top_chk #(
	parameter int MS_TICKS = 8
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic [1:0] O_RRESP,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic O_IRQ,
	input wire logic I_DP,
	input wire logic I_DM,
	input wire logic O_LINE_STABLE
);
	// Enables are always at least two core cycles apart, so this is a safe floor
	localparam int LS_MIN = 2 * MS_TICKS - 2;
	logic [7:0] ar_q;
	logic [1:0] ln, ln_q;
	logic [31:0] quiet;
	assign ln = {!I_DP && !I_DM, I_DP && !I_DM};
	always_ff @(posedge I_CORE_CLK) begin
		ln_q <= ln;
		if (I_ARVALID && O_ARREADY) ar_q <= I_ARADDR;
		if (!I_RST_B || ln != ln_q) quiet <= 32'h00000000;
		else if (quiet != 32'hFFFFFFFF) quiet <= quiet + 32'h00000001;
	end
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_B);
	sequence s_ar_take;
		I_ARVALID && O_ARREADY;
	endsequence
	sequence s_ln_drop;
		##[1:8] !O_LINE_STABLE;
	endsequence
	chk_rst_idle: assert property ($rose(I_RST_B) |-> !O_IRQ && !O_BVALID && !O_RVALID)
		else $error("outputs not idle after reset");
	chk_rd_next: assert property (s_ar_take |=> O_RVALID)
		else $error("read answer not one cycle after address");
	chk_rd_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read answer dropped or changed");
	chk_wr_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write answer dropped or changed");
	chk_ar_block: assert property (O_RVALID |-> !O_ARREADY)
		else $error("address accepted while read pending");
	chk_upper_zero: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	chk_bit1_zero: assert property (O_RVALID && ar_q == 8'h00 |-> !O_RDATA[1])
		else $error("unused flag bit reads one");
	chk_unmapped_err: assert property (O_RVALID && ar_q > 8'h0C |-> O_RRESP == 2'h2)
		else $error("unmapped read not refused");
	chk_line_drop: assert property (ln != ln_q && O_LINE_STABLE |-> s_ln_drop)
		else $error("line status kept after line change");
	chk_line_rise: assert property ($rose(O_LINE_STABLE) |-> quiet >= LS_MIN)
		else $error("line status rose too early");
endmodule
`default_nettype wire

// ### usbofe_peer.sv
// Behavioural cable peer and comparators driving the OTG pins
`timescale 1ns/10ps
`default_nettype none
module usbofe_peer (
	input wire logic i_clk,
	output var logic [5:0] o_pins
);
	// Order id, dp, dm, sess valid, sess end, vbus valid; idle is J with no cable
	initial o_pins = 6'h32;
	// Edge-aligned moves only; asynchronous skew is left to the synchroniser
	task move(input logic [5:0] v);
		@(posedge i_clk);
		o_pins <= v;
	endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the OTG event-flag block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int MS = 8;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wdt = 32'h00000000, rd_o;
	logic [5:0] pins;
	logic awr, wrr, bv, arr, rv, irq, lsp, eng_en, dma, lstab;
	logic [1:0] br, rr;
	logic [2:0] mode;
	logic [5:0] tg [3] = '{6'h02, 6'h01, 6'h02};
	logic [7:0] ex [3] = '{8'h04, 8'h01, 8'h0C};
	int error_cnt = 0, total_checks = 0, cyc = 0;
	usbofe_peer peer (.i_clk(clk), .o_pins(pins));
	usbofe_top #(.MS_TICKS(MS)) uut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrr), .I_WDATA(wdt),
		.I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(brdy), .O_BRESP(br), .I_ARVALID(arv),
		.O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rrdy), .O_RDATA(rd_o),
		.O_RRESP(rr), .I_ID(pins[5]), .I_DP(pins[4]), .I_DM(pins[3]), .I_SESS_VALID(pins[2]),
		.I_SESS_END(pins[1]), .I_VBUS_VALID(pins[0]), .O_IRQ(irq), .O_MODE(mode),
		.O_LOW_SPEED(lsp), .O_SERIAL_ENGINE_EN(eng_en), .O_DMA_EN(dma), .O_LINE_STABLE(lstab));
	initial forever #4 clk = ~clk;
	task give_verdict();
		if (error_cnt == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wdt <= d;
		brdy <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrr) wv <= 1'b0;
		end while (!bv);
		chk(32'(br), 32'(er));
		brdy <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rrdy <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		chk(32'(rr), 32'(er));
		chk(rd_o & m, e);
		rrdy <= 1'b0;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'h00, 32'hFFFFFF9F, 32'h0, 2'h0);
		rd(8'h04, 32'hFFFFFFFF, 32'h0, 2'h0);
		rd(8'h0C, 32'hFFFFFFFF, 32'h2, 2'h0);
		chk(32'(mode), 32'h2);
		wr(8'h04, 32'hFFFFFFFF, 2'h0);
		rd(8'h04, 32'hFFFFFFFF, 32'hFD, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h10, 32'hFF, 2'h2);
		rd(8'h10, 32'hFFFFFFFF, 32'h0, 2'h2);
		tick(60);
		rd(8'h00, 32'h60, 32'h60, 2'h0);
		chk(32'(lstab), 32'h1);
		wr(8'h00, 32'hFF, 2'h0);
		tick(60);
		rd(8'h00, 32'h20, 32'h0, 2'h0);
		peer.move(pins ^ 6'h20);
		tick(8);
		rd(8'h00, 32'h80, 32'h80, 2'h0);
		chk(32'(irq), 32'h0);
		wr(8'h00, 32'h0, 2'h0);
		rd(8'h00, 32'h80, 32'h80, 2'h0);
		wr(8'h00, 32'h80, 2'h0);
		rd(8'h00, 32'h80, 32'h0, 2'h0);
		wr(8'h00, 32'hFFFFFFFF, 2'h0);
		rd(8'h00, 32'hFFFFFF02, 32'h0, 2'h0);
		wr(8'h04, 32'h80, 2'h0);
		peer.move(pins ^ 6'h20);
		tick(8);
		chk(32'(irq), 32'h1);
		wr(8'h04, 32'h0, 2'h0);
		chk(32'(irq), 32'h0);
		wr(8'h04, 32'h80, 2'h0);
		chk(32'(irq), 32'h1);
		wr(8'h00, 32'h80, 2'h0);
		chk(32'(irq), 32'h0);
		for (int k = 0; k < 3; k++) begin
			wr(8'h00, 32'hFF, 2'h0);
			peer.move(pins ^ tg[k]);
			tick(8);
			rd(8'h00, 32'h0D, 32'(ex[k]), 2'h0);
		end
		wr(8'h08, 32'hFF, 2'h0);
		rd(8'h08, 32'h8D, 32'h85, 2'h0);
		wr(8'h0C, 32'h42, 2'h0);
		rd(8'h0C, 32'hFF, 32'h42, 2'h0);
		wr(8'h00, 32'hFF, 2'h0);
		peer.move(pins ^ 6'h08);
		tick(8);
		rd(8'h00, 32'h10, 32'h10, 2'h0);
		chk(32'(lstab), 32'h0);
		wr(8'h0C, 32'h39, 2'h0);
		rd(8'h0C, 32'hFF, 32'h39, 2'h0);
		chk(32'(mode), 32'h1);
		chk(32'(lsp), 32'h1);
		chk(32'(eng_en), 32'h1);
		chk(32'(dma), 32'h1);
		wr(8'h0C, 32'h0C, 2'h0);
		rd(8'h0C, 32'hFF, 32'h04, 2'h0);
		chk(32'(lsp), 32'h0);
		chk(32'(eng_en), 32'h0);
		chk(32'(dma), 32'h0);
		wr(8'h0C, 32'h33, 2'h0);
		rd(8'h0C, 32'hFF, 32'h34, 2'h0);
		chk(32'(mode), 32'h4);
		give_verdict();
	end
endmodule
bind usbofe_top usbofe_top_chk #(.MS_TICKS(MS_TICKS)) chk_i (.I_CORE_CLK, .I_RST_B,
	.I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP, .O_BVALID,
	.I_BREADY, .O_BRESP, .O_IRQ, .I_DP, .I_DM, .O_LINE_STABLE);
`default_nettype wire
